// *** rtl/cfg_link_host.sv ***
// host controller that programs shutdown delay and retry wait over the link
// What this block does
// - control input low selects config; status pin becomes device input
// - host holds control input low during the whole frame
// - each frame is exactly 21 Manchester coded bits
// - rising mid-cell edge means one, falling mid-cell edge means zero
// - bit rate kept inside 396 to 540 kHz, nominally 450 kHz
// - delay frame header pattern, bit 17 one, complement then true code
// - wait frame header pattern, bit 17 one, complement then true code
// - delay frame bits 14 to 16 complement delay code
// - wait frame bits 14 to 16 complement wait code
// - host resends wait whenever delay changes
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module cfg_link_host
  import cfg_link_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  output logic            ctrl_in,
  output logic            status_out,
  output logic            status_oe,
  input  wire logic       status_in
);
  link_state_e state;
  logic [2:0]  delay_code;
  logic [2:0]  wait_code;
  logic        run;
  logic        pend_delay;
  logic        pend_wait;
  logic        cur_wait;
  logic [20:0] frame;
  logic [4:0]  bit_idx;
  logic        half;
  logic [7:0]  setup_cnt;
  logic        tick;
  logic        stat_s1;
  logic        stat_s2;
  logic        busy;

  // one decode for every register write strobe
  function automatic logic hits(input logic       stb,
                                input logic [7:0] at,
                                input logic [7:0] want);
    hits = stb && (at == want);
  endfunction : hits

  function automatic logic [13:0] rev14(input logic [13:0] v);
    for (int k = 0; k < 14; k++) begin
      rev14[k] = v[13 - k];
    end
  endfunction : rev14

  half_cell_tick u_tick (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .run     (state == ST_SEND),
    .tick    (tick)
  );

  assign busy = (state != ST_IDLE);

  // status pin is only sampled for software; it is a device output in use
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      stat_s1 <= 1'b0;
      stat_s2 <= 1'b0;
    end else begin
      stat_s1 <= status_in;
      stat_s2 <= stat_s1;
    end
  end

  // code registers start at the device's own defaults
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      delay_code <= DELAY_DEFAULT;
      wait_code  <= WAIT_DEFAULT;
      run        <= 1'b0;
    end else if (hits(wr, addr, ADDR_CODES)) begin
      delay_code <= wdata[2:0];
      wait_code  <= wdata[6:4];
    end else if (hits(wr, addr, ADDR_CTRL)) begin
      run <= wdata[CTRL_RUN];
    end
  end

  // a delay request always drags a wait frame along to keep the ratio
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pend_delay <= 1'b0;
      pend_wait  <= 1'b0;
    end else begin
      if (state == ST_IDLE && pend_delay)
        pend_delay <= 1'b0;
      else if (state == ST_IDLE && pend_wait)
        pend_wait <= 1'b0;
      if (hits(wr, addr, ADDR_CTRL)) begin
        if (wdata[CTRL_GO_DELAY]) begin
          pend_delay <= 1'b1;
          pend_wait  <= 1'b1;
        end
        if (wdata[CTRL_GO_WAIT])
          pend_wait <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state     <= ST_IDLE;
      frame     <= '0;
      cur_wait  <= 1'b0;
      bit_idx   <= 5'h00;
      half      <= 1'b0;
      setup_cnt <= 8'h00;
    end else begin
      case (state)
        ST_IDLE: begin
          if (pend_delay || pend_wait) begin
            cur_wait  <= !pend_delay;
            frame     <= build_frame(!pend_delay,
                           pend_delay ? delay_code : wait_code);
            setup_cnt <= 8'h00;
            state     <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (setup_cnt == 8'(SETUP_CYCLES - 1)) begin
            bit_idx <= 5'h00;
            half    <= 1'b0;
            state   <= ST_SEND;
          end else begin
            setup_cnt <= setup_cnt + 8'h01;
          end
        end
        ST_SEND: begin
          if (tick) begin
            half <= ~half;
            if (half) begin
              if (bit_idx == 5'(FRAME_BITS - 1))
                state <= ST_END;
              else
                bit_idx <= bit_idx + 5'h01;
            end
          end
        end
        ST_END: begin
          if (setup_cnt == 8'h00)
            state <= ST_IDLE;
          else
            setup_cnt <= setup_cnt - 8'h01;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // first half carries the complement so the mid-cell edge gives the bit
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      status_out <= 1'b0;
      status_oe  <= 1'b0;
      ctrl_in    <= 1'b0;
    end else begin
      // low while a frame is queued too, so no stray output pulse
      // slips in between the delay frame and its wait frame
      ctrl_in <= (busy || pend_delay || pend_wait) ? 1'b0 : run;
      if (state == ST_SEND) begin
        status_oe  <= 1'b1;
        status_out <= half ? frame[bit_idx] : ~frame[bit_idx];
      end else begin
        status_oe  <= (state == ST_SETUP);
        status_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (rd) begin
      if (addr == ADDR_CTRL)
        rdata <= {5'h00, run, 2'b00};
      else if (addr == ADDR_CODES)
        rdata <= {1'b0, wait_code, 1'b0, delay_code};
      else if (addr == ADDR_STATUS)
        rdata <= {4'h0, cur_wait, pend_delay | pend_wait, stat_s2, busy};
      else
        rdata <= 8'h00;
    end else begin
      rdata <= 8'h00;
    end
  end

  // helper counters for the timing checks; tick_gap saturates rather than wraps
  logic [7:0] tick_gap;
  logic [5:0] halves_sent;

  always_ff @(posedge clk_sys) begin
    if (!rstn || tick) begin
      tick_gap <= 8'h00;
    end else if (tick_gap != 8'hff) begin
      tick_gap <= tick_gap + 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn || state == ST_SETUP) begin
      halves_sent <= 6'h00;
    end else if (state == ST_SEND && tick) begin
      halves_sent <= halves_sent + 6'h01;
    end
  end

  default clocking chk_clk @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  AST_CTRL_LOW_IN_FRAME: assert property (
    (state == ST_SEND) |-> ##1 !ctrl_in)
    else $error("control high during frame");

  AST_OE_IN_SEND: assert property (
    (state == ST_SEND) |=> status_oe)
    else $error("status pin not driven during frame");

  AST_RELEASE_IDLE: assert property (
    (state == ST_IDLE && $past(state) == ST_IDLE) |-> !status_oe)
    else $error("status pin driven while idle");

  AST_BIT_LIMIT: assert property (
    bit_idx <= 5'(FRAME_BITS - 1))
    else $error("bit index past frame");

  AST_MID_EDGE: assert property (
    (state == ST_SEND && tick && !half) |-> ##2 status_out == frame[bit_idx])
    else $error("mid cell level wrong");

  AST_RATIO: assert property (
    hits(wr, addr, ADDR_CTRL) && wdata[CTRL_GO_DELAY] |=> pend_wait)
    else $error("wait frame not queued with delay");

  AST_BIT17: assert property (
    (state == ST_SEND) |-> frame[17] && frame[16:14] == ~frame[20:18])
    else $error("frame check fields wrong");

  AST_HDR_FIELD: assert property (
    (state == ST_SEND) |->
      frame[13:0] == rev14(cur_wait ? HDR_WAIT : HDR_DELAY))
    else $error("frame header pattern wrong");

  AST_HALF_RATE: assert property (
    (state == ST_SEND && tick) |-> tick_gap >= 8'(HALF_CYCLES - 1))
    else $error("half cell too short");

  AST_HALF_STEADY: assert property (
    (state == ST_SEND && tick && half) |-> tick_gap == 8'(HALF_CYCLES - 1))
    else $error("half cell length drifts");

  AST_FRAME_LEN: assert property (
    (state == ST_END && $past(state) == ST_SEND) |->
      halves_sent == 6'(2 * FRAME_BITS))
    else $error("frame cell count wrong");

  AST_SETUP_QUIET: assert property (
    (state == ST_SETUP && $past(state) == ST_SETUP) |->
      status_oe && !status_out && !ctrl_in)
    else $error("lead-in not held low");

  AST_END_RELEASED: assert property (
    (state == ST_END && $past(state) == ST_END) |-> !status_oe && !ctrl_in)
    else $error("pin not released after frame");

  AST_CTRL_RUN_IDLE: assert property (
    (state == ST_IDLE && $past(state) == ST_IDLE &&
     !$past(pend_delay || pend_wait)) |-> ctrl_in == $past(run))
    else $error("control does not follow run while idle");

  AST_PEND_START: assert property (
    (state == ST_IDLE && (pend_delay || pend_wait)) |=> state == ST_SETUP)
    else $error("queued frame not started");

  AST_DELAY_FIRST: assert property (
    (state == ST_IDLE && pend_delay) |=> !cur_wait && pend_wait)
    else $error("delay frame not sent ahead of its wait frame");

  COV_DELAY: cover property (state == ST_SEND && !cur_wait);
  COV_WAIT: cover property (state == ST_SEND && cur_wait);
  COV_DONE: cover property (state == ST_END ##1 state == ST_IDLE);
  COV_REQUEUE: cover property (
    state == ST_SETUP && hits(wr, addr, ADDR_CTRL) && wdata[CTRL_GO_WAIT]);
endmodule : cfg_link_host

// *** rtl/cfg_link_pkg.sv ***
// constants for the host-side timing-configuration link controller
package cfg_link_pkg;
  localparam int         FRAME_BITS     = 21;
  localparam int         CLK_SYS_HZ     = 10000000;
  localparam int         DATA_CLK_HZ    = 450000;
  // half bit cell in system cycles, rounded down so the rate stays at or above 450 kHz
  localparam int         HALF_CYCLES    = CLK_SYS_HZ / (2 * DATA_CLK_HZ);
  localparam int         SETUP_CYCLES   = 2 * HALF_CYCLES;
  localparam logic [13:0] HDR_DELAY     = 14'b10110000011110;
  localparam logic [13:0] HDR_WAIT      = 14'b10110000100010;
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_CODES    = 8'h04;
  localparam logic [7:0]  ADDR_STATUS   = 8'h08;
  localparam int         CTRL_GO_DELAY  = 0;
  localparam int         CTRL_GO_WAIT   = 1;
  localparam int         CTRL_RUN       = 2;
  localparam logic [2:0]  DELAY_DEFAULT = 3'h0;
  localparam logic [2:0]  WAIT_DEFAULT  = 3'h0;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SETUP = 2'b01,
    ST_SEND  = 2'b10,
    ST_END   = 2'b11
  } link_state_e;

  // frame bit order is index 0 first
  function automatic logic [20:0] build_frame(input logic is_wait,
                                              input logic [2:0] code);
    logic [13:0] hdr;
    hdr = is_wait ? HDR_WAIT : HDR_DELAY;
    build_frame = {code[0], code[1], code[2], 1'b1, ~code[0], ~code[1],
                   ~code[2], hdr[0], hdr[1], hdr[2], hdr[3], hdr[4], hdr[5],
                   hdr[6], hdr[7], hdr[8], hdr[9], hdr[10], hdr[11], hdr[12],
                   hdr[13]};
  endfunction : build_frame
endpackage : cfg_link_pkg

// *** rtl/half_cell_tick.sv ***
// half-bit-cell enable divider
`timescale 1ns/1ns
module half_cell_tick
  import cfg_link_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic run,
  output logic      tick
);
  logic [7:0] cnt;

  always_ff @(posedge clk_sys) begin
    if (!rstn || !run) begin
      cnt  <= 8'h00;
      tick <= 1'b0;
    end else if (cnt == 8'(HALF_CYCLES - 1)) begin
      cnt  <= 8'h00;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + 8'h01;
      tick <= 1'b0;
    end
  end
endmodule : half_cell_tick

// *** verif/dev_model.sv ***
// behavioural device model that decodes timing frames on the status wire
`timescale 1ns/1ns
module dev_model (
  input  wire logic       clk_sys,
  input  wire logic       ctrl_in,
  input  wire logic       pin,
  input  wire logic       oe,
  output logic            drive,
  output logic      [2:0] delay_code,
  output logic      [2:0] wait_code,
  output int              delay_us,
  output int              wait_ms,
  output int              n_frames,
  output int              n_bad
);
  // index 0 is the first bit on the wire
  localparam logic [13:0] HDR_D = 14'b01111000001101;
  localparam logic [13:0] HDR_W = 14'b01000100001101;
  localparam int DEL_US[8] = '{50, 5, 10, 20, 100, 200, 500, 1000};
  localparam int WAIT_MS[8] = '{500, 10, 20, 50, 100, 200, 1000, 1500};
  logic [20:0] f;
  logic        last, armed;
  int          idx, gap;
  wire logic [2:0] code = {f[18], f[19], f[20]};
  wire logic [2:0] cmpl = {f[14], f[15], f[16]};
  // no over-current is modelled: the drive never trips, so the retry
  // timing shows only through the stored codes
  assign drive = ctrl_in;
  assign delay_us = DEL_US[delay_code];
  assign wait_ms = WAIT_MS[wait_code];
  // only power-on sets the defaults: the store is volatile
  initial begin
    delay_code = 3'h0;
    wait_code = 3'h0;
    {n_frames, n_bad, idx, gap} = '0;
    {last, armed} = 2'b10;
  end
  always @(posedge clk_sys) begin
    last <= pin;
    gap <= gap + 1;
    if (oe && ctrl_in && armed && idx < 21) n_bad <= n_bad + 1;
    if (ctrl_in || !oe) begin
      armed <= 1'b0;
      idx <= 0;
    end else if (pin != last && idx < 21 && (armed ? gap > 14 : pin)) begin
      if (armed && (gap < 17 || gap > 25)) n_bad <= n_bad + 1;
      armed <= 1'b1;
      gap <= 0;
      f[idx] <= pin;
      idx <= idx + 1;
    end else if (armed && idx == 21) begin
      idx <= 22;
      n_frames <= n_frames + 1;
      if (f[17] && cmpl == ~code && f[13:0] == HDR_D)
        delay_code <= code;
      else if (f[17] && cmpl == ~code && f[13:0] == HDR_W)
        wait_code <= code;
      else
        n_bad <= n_bad + 1;
    end
  end
endmodule : dev_model

// *** verif/testbench.sv ***
// bench that programs codes over the register port and checks the device
`timescale 1ns/1ns
module testbench;
  import cfg_link_pkg::*;
  logic       clk_sys = 1'b0;
  logic       rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata, got;
  logic       ctrl_in, status_out, status_oe, drive;
  logic [2:0] delay_code, wait_code;
  int         n_frames, n_bad, delay_us, wait_ms, i;
  int         mismatches = 0;
  int         n_compared = 0;
  // released wire floats high through the pull-up
  wire logic  pin = status_oe ? status_out : 1'b1;
  always #50 clk_sys = ~clk_sys;
  cfg_link_host cfg_link_host_i (.clk_sys(clk_sys), .rstn(rstn),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .ctrl_in(ctrl_in), .status_out(status_out), .status_oe(status_oe),
    .status_in(pin));
  dev_model dev_model_i (.clk_sys(clk_sys), .ctrl_in(ctrl_in), .pin(pin),
    .oe(status_oe), .drive(drive), .delay_code(delay_code),
    .wait_code(wait_code), .delay_us(delay_us), .wait_ms(wait_ms),
    .n_frames(n_frames), .n_bad(n_bad));
  task automatic test_done;
    if (mismatches == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] seen);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(negedge clk_sys);
    d = rdata;
  endtask : rd_reg
  // polls busy under a bound so a stuck link cannot hang the run
  task automatic wait_idle;
    int k;
    repeat (2) @(posedge clk_sys);
    for (k = 0; k < 3000; k++) begin
      rd_reg(ADDR_STATUS, got);
      if (got[0] === 1'b0 && got[2] === 1'b0) break;
    end
    chk("busy", 0, got[0]);
    chk("pending", 0, got[2]);
  endtask : wait_idle
  initial begin
    #(40000 * 100);
    mismatches++;
    test_done;
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    rd_reg(ADDR_CODES, got);
    chk("codes", 0, got);
    chk("delay_us", 50, delay_us);
    chk("wait_ms", 500, wait_ms);
    rd_reg(8'h0c, got);
    chk("unmapped", 0, got);
    wr_reg(ADDR_CTRL, 8'h04);
    repeat (3) @(posedge clk_sys);
    chk("ctrl idle", 1, ctrl_in);
    chk("oe idle", 0, status_oe);
    for (i = 0; i < 8; i++) begin
      wr_reg(ADDR_CODES, {1'b0, 3'(7 - i), 1'b0, 3'(i)});
      wr_reg(ADDR_CTRL, 8'h05);
      wait_idle();
      chk("delay", i, delay_code);
      chk("wait", 7 - i, wait_code);
      chk("frames", 2 * i + 2, n_frames);
    end
    // a second go while busy is queued, not lost
    wr_reg(ADDR_CODES, 8'h52);
    wr_reg(ADDR_CTRL, 8'h06);
    wr_reg(ADDR_CTRL, 8'h06);
    repeat (5) @(posedge clk_sys);
    chk("drive cfg", 0, drive);
    chk("oe cfg", 1, status_oe);
    wait_idle();
    chk("delay kept", 7, delay_code);
    chk("wait new", 5, wait_code);
    chk("frames", 18, n_frames);
    chk("ctrl back", 1, ctrl_in);
    chk("bad", 0, n_bad);
    chk("delay_us", 1000, delay_us);
    chk("wait_ms", 200, wait_ms);
    chk("drive", 1, drive);
    rd_reg(ADDR_STATUS, got);
    chk("status", 8'h0a, got);
    rd_reg(ADDR_CODES, got);
    chk("codes", 8'h52, got);
    rd_reg(ADDR_CTRL, got);
    chk("ctrl", 8'h04, got);
    test_done;
  end
endmodule : testbench
